// ===== ptsu_pkg.sv
/*
 * Package for the pulse-per-second timing and status unit: register map,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock; the reference clock enters as an enable.
 */
package ptsu_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ      = 100_000_000;
    localparam int unsigned REF_CLK_HZ       = 10_000_000;
    localparam int unsigned CORE_PERIOD_NS   = 1_000_000_000 / CORE_CLK_HZ;
    localparam int unsigned STEP_NS          = 10;
    localparam int unsigned STEP_CYCLES      = (STEP_NS + CORE_PERIOD_NS - 1)
                                               / CORE_PERIOD_NS;
    localparam int unsigned SECOND_CYCLES    = CORE_CLK_HZ;
    localparam int unsigned WIDTH_DEF_US     = 20;
    localparam int unsigned WIDTH_DEF_CYCLES = WIDTH_DEF_US * 1000
                                               / CORE_PERIOD_NS;
    localparam int unsigned SEEN_TIMEOUT_MS  = 1100;
    localparam int unsigned SEEN_TIMEOUT_CYC = SEEN_TIMEOUT_MS
                                               * (CORE_CLK_HZ / 1000);
    localparam int unsigned TOL_NS           = 50;
    localparam int unsigned TOL_CYCLES       = TOL_NS / CORE_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_OFFSET0  = 8'h04;
    localparam logic [7:0] OFS_OFFSET1  = 8'h08;
    localparam logic [7:0] OFS_WIDTH    = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;
    localparam logic [7:0] OFS_ALARM    = 8'h20;
    localparam logic [7:0] OFS_CONSOLE  = 8'h24;

    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SEL_BIT   = 0;
    localparam int unsigned CTRL_ACK_BIT   = 1;
    localparam int unsigned ST_SEEN_BIT    = 0;
    localparam int unsigned ST_LOCK_BIT    = 1;
    localparam int unsigned ST_ALARM_BIT   = 2;
    localparam int unsigned IRQ_PPS_BIT    = 0;
    localparam int unsigned IRQ_SEEN_BIT   = 1;
    localparam int unsigned IRQ_LOCK_BIT   = 2;
    localparam int unsigned IRQ_ALARM_BIT  = 3;
    localparam int unsigned IRQ_BITS       = 4;
    localparam int unsigned ALARM_BITS     = 8;

    // Console settings: rate code, data bits, parity, stop, flow
    localparam logic [1:0] BAUD_57600   = 2'h0;
    localparam logic [1:0] BAUD_230400  = 2'h1;
    localparam logic [1:0] BAUD_921600  = 2'h2;
    localparam logic [3:0] DATA_BITS    = 4'h8;
    localparam logic [1:0] STOP_BITS    = 2'h1;
    localparam logic [31:0] ERR_DATA    = 32'hdead_0bad;

    typedef struct packed {
        logic        sel;
        logic [31:0] offset0;
        logic [31:0] offset1;
        logic [31:0] width;
        logic [1:0]  baud;
    } ptsu_cfg_type;

endpackage

// ===== ptsu_top.sv
/*
 * Pulse-per-second timing and status unit with an APB register slave.
 * Assumes the 10 MHz reference arrives as a core-synchronous enable pulse
 * and that both pps inputs and the lock and alarm causes are synchronous.
 */
module ptsu_top #(
    parameter int unsigned SECOND_CYC = ptsu_pkg::SECOND_CYCLES,
    parameter int unsigned TIMEOUT_CYC = ptsu_pkg::SEEN_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Reference and pulse inputs
    input  wire logic        ref_tick_i,
    input  wire logic        pps_input_zero_i,
    input  wire logic        pps_input_one_i,
    // Status causes
    input  wire logic        osc_locked_i,
    input  wire logic [7:0]  alarm_cause_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Outputs
    output logic             ref_out_o,
    output logic             pps_output_o,
    output logic             lock_indicator_n_o,
    output logic             alarm_o,
    output logic             irq_o,
    output logic      [1:0]  console_baud_o
);

    // Elaboration check: the presence timeout must outlast one second
    if (SECOND_CYC < 1000 || TIMEOUT_CYC <= SECOND_CYC) begin : gen_bad_cfg
        $error("ptsu_top: bad second or timeout count");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    ptsu_pkg::ptsu_cfg_type cfg;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [7:0]  alarm_bits;
    logic        alarm_held;
    logic        seen;
    logic        locked_q;
    logic        pps_sel_q;
    logic [31:0] sec_cnt;
    logic [31:0] wid_cnt;
    logic [31:0] gap_cnt;
    logic        ref_div;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire acc      = psel_i && penable_i;
    wire wr       = acc && pwrite_i;
    wire wr_ctrl  = wr && paddr_i == ptsu_pkg::OFS_CTRL;
    wire wr_off0  = wr && paddr_i == ptsu_pkg::OFS_OFFSET0;
    wire wr_off1  = wr && paddr_i == ptsu_pkg::OFS_OFFSET1;
    wire wr_width = wr && paddr_i == ptsu_pkg::OFS_WIDTH;
    wire wr_clr   = wr && paddr_i == ptsu_pkg::OFS_IRQ_CLR;
    wire wr_en    = wr && paddr_i == ptsu_pkg::OFS_IRQ_EN;
    wire wr_cons  = wr && paddr_i == ptsu_pkg::OFS_CONSOLE;
    wire ack_alm  = wr_ctrl && pwdata_i[ptsu_pkg::CTRL_ACK_BIT];
    wire baud_ok  = pwdata_i[1:0] != 2'h3;
    wire mapped   = paddr_i[1:0] == 2'h0 && paddr_i <= ptsu_pkg::OFS_CONSOLE;

    // Read mux, status words built from live state
    wire [31:0] status_word = {29'h0, alarm_held, locked_q, seen};
    wire [31:0] cons_word   = {22'h0, 1'b0, 1'b0, ptsu_pkg::STOP_BITS,
                               ptsu_pkg::DATA_BITS, cfg.baud};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (paddr_i)
            ptsu_pkg::OFS_CTRL:     rd_mux = {31'h0, cfg.sel};
            ptsu_pkg::OFS_OFFSET0:  rd_mux = cfg.offset0;
            ptsu_pkg::OFS_OFFSET1:  rd_mux = cfg.offset1;
            ptsu_pkg::OFS_WIDTH:    rd_mux = cfg.width;
            ptsu_pkg::OFS_STATUS:   rd_mux = status_word;
            ptsu_pkg::OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            ptsu_pkg::OFS_IRQ_EN:   rd_mux = {28'h0, irq_en};
            ptsu_pkg::OFS_ALARM:    rd_mux = {24'h0, alarm_bits};
            ptsu_pkg::OFS_CONSOLE:  rd_mux = cons_word;
            default:                rd_mux = 32'h0;
        endcase
    end

    // Zero-wait slave: ready pulses in the access cycle
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ?
                         (mapped ? rd_mux : ptsu_pkg::ERR_DATA) : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------
    wire pps_edge_go;
    // Selection written only at a second boundary is not needed:
    // a change takes effect at once and restarts presence timing.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg.sel     <= 1'b0;
            cfg.offset0 <= 32'h0;
            cfg.offset1 <= 32'h0;
            cfg.width   <= 32'(ptsu_pkg::WIDTH_DEF_CYCLES);
            cfg.baud    <= ptsu_pkg::BAUD_57600;
            irq_en      <= 4'h0;
        end else begin
            if (wr_ctrl)
                cfg.sel <= pwdata_i[ptsu_pkg::CTRL_SEL_BIT];
            if (wr_off0)
                cfg.offset0 <= pwdata_i;
            if (wr_off1)
                cfg.offset1 <= pwdata_i;
            if (wr_width && pwdata_i != 32'h0)
                cfg.width <= pwdata_i;
            if (wr_cons && baud_ok)
                cfg.baud <= pwdata_i[1:0];
            if (wr_en)
                irq_en <= pwdata_i[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Input selection and presence detection
    // ------------------------------------------------------------------
    wire pps_in = cfg.sel ? pps_input_one_i : pps_input_zero_i;
    wire [31:0] act_offset = cfg.sel ? cfg.offset1 : cfg.offset0;
    wire pps_rise = pps_in && !pps_sel_q;
    wire sel_chg  = wr_ctrl && (pwdata_i[ptsu_pkg::CTRL_SEL_BIT] != cfg.sel);

    // Presence: edges no further apart than the timeout
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pps_sel_q <= 1'b0;
            gap_cnt   <= 32'h0;
            seen      <= 1'b0;
        end else begin
            pps_sel_q <= pps_in;
            if (sel_chg) begin
                gap_cnt <= 32'h0;
                seen    <= 1'b0;
            end else if (pps_rise) begin
                gap_cnt <= 32'h0;
                seen    <= 1'b1;
            end else if (gap_cnt >= TIMEOUT_CYC - 1) begin
                seen    <= 1'b0;
            end else begin
                gap_cnt <= gap_cnt + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reference output and second divider
    // ------------------------------------------------------------------
    // Counter runs on core cycles; the core clock is locked to the
    // reference, so the output edge keeps its place against it.
    wire sec_wrap = sec_cnt >= SECOND_CYC - 1;
    wire [31:0] off_mod = act_offset % SECOND_CYC;
    assign pps_edge_go = sec_cnt == off_mod;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ref_div <= 1'b0;
            sec_cnt <= 32'h0;
        end else begin
            if (ref_tick_i)
                ref_div <= !ref_div;
            sec_cnt <= sec_wrap ? 32'h0 : sec_cnt + 32'h1;
        end
    end

    // Pulse generation, width in 10 ns ticks
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pps_output_o <= 1'b0;
            wid_cnt      <= 32'h0;
        end else if (pps_edge_go) begin
            pps_output_o <= 1'b1;
            wid_cnt      <= cfg.width - 32'h1;
        end else if (wid_cnt != 32'h0) begin
            wid_cnt      <= wid_cnt - 32'h1;
        end else begin
            pps_output_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Lock, alarm and interrupts
    // ------------------------------------------------------------------
    wire [7:0] next_alarm_bits = (ack_alm ? 8'h0 : alarm_bits) | alarm_cause_i;
    wire lock_chg = osc_locked_i != locked_q;
    // Input event on every selected edge, which also refreshes presence unless a select change is written in the same cycle
    wire [3:0] irq_set = {|alarm_cause_i, lock_chg, pps_rise, pps_edge_go};
    wire [3:0] irq_keep = wr_clr ? (irq_stat & ~pwdata_i[3:0]) : irq_stat;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            locked_q   <= 1'b0;
            alarm_bits <= 8'h0;
            alarm_held <= 1'b0;
            irq_stat   <= 4'h0;
        end else begin
            locked_q   <= osc_locked_i;
            alarm_bits <= next_alarm_bits;
            alarm_held <= |next_alarm_bits;
            irq_stat   <= irq_keep | irq_set; // Set wins over clear
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ref_out_o          <= 1'b0;
            lock_indicator_n_o <= 1'b1;
            alarm_o            <= 1'b0;
            irq_o              <= 1'b0;
            console_baud_o     <= ptsu_pkg::BAUD_57600;
        end else begin
            ref_out_o          <= ref_div;
            lock_indicator_n_o <= !locked_q;
            alarm_o            <= alarm_held;
            irq_o              <= |(irq_stat & irq_en);
            console_baud_o     <= cfg.baud;
        end
    end

endmodule

// ===== ptsu_props.sv
/* Port checker for the pps timing and status unit.
   Assumes one core clock and a synchronous active-low reset. */
module ptsu_props #(
    parameter int unsigned SECOND_CYC = ptsu_pkg::SECOND_CYCLES
) (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        ref_tick_i,
    input wire logic        osc_locked_i,
    input wire logic [7:0]  alarm_cause_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        ref_out_o,
    input wire logic        pps_output_o,
    input wire logic        lock_indicator_n_o,
    input wire logic        alarm_o,
    input wire logic [1:0]  console_baud_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // Helpers: a write may move the second, so skip the next two gaps
    // -----------------------------------------------------------------
    logic        pps_q;
    logic [1:0]  wr_skip;
    logic [31:0] gap;
    wire         wr_acc = psel_i & penable_i & pwrite_i;
    wire         ack = wr_acc & (paddr_i == ptsu_pkg::OFS_CTRL) & pwdata_i[1];
    wire         rise = pps_output_o & ~pps_q;
    always_ff @(posedge core_clk_i) begin
        pps_q   <= pps_output_o;
        gap     <= (!rst_n_i || rise) ? 32'h1 : gap + 32'h1;
        if (!rst_n_i || wr_acc)
            wr_skip <= 2'h2;
        else if (rise && wr_skip != 2'h0)
            wr_skip <= wr_skip - 2'h1;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    lock_follow_a: assert property ($past(rst_n_i, 2) &&
        $past(rst_n_i) |->
        lock_indicator_n_o == !$past(osc_locked_i, 2))
        else $error("lock pin");
    ref_toggle_a: assert property (ref_tick_i |-> ##2
        ref_out_o != $past(ref_out_o)) else $error("ref no toggle");
    ref_hold_a: assert property (!ref_tick_i |-> ##2
        $stable(ref_out_o)) else $error("ref moved");
    pps_period_a: assert property (rise && wr_skip == 2'h0 |->
        gap == SECOND_CYC) else $error("pps period");
    alarm_set_a: assert property ((|alarm_cause_i) |->
        ##[1:2] alarm_o) else $error("alarm not set");
    alarm_hold_a: assert property ($past(rst_n_i) && $fell(alarm_o) |->
        $past(ack) || $past(ack, 2)) else $error("alarm dropped");
    ready_time_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready");
    slverr_qual_a: assert property (pslverr_o |-> pready_o && penable_i)
        else $error("stray slverr");
    err_data_a: assert property (pready_o && pslverr_o && !pwrite_i |->
        prdata_o == ptsu_pkg::ERR_DATA) else $error("error data");
    baud_reset_a: assert property ($rose(rst_n_i) |->
        console_baud_o == ptsu_pkg::BAUD_57600) else $error("baud reset");
    baud_legal_a: assert property (console_baud_o != 2'h3)
        else $error("baud code");
endmodule

bind ptsu_top ptsu_props #(.SECOND_CYC(SECOND_CYC)) props_u (.core_clk_i,
    .rst_n_i, .ref_tick_i, .osc_locked_i, .alarm_cause_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .ref_out_o, .pps_output_o, .lock_indicator_n_o, .alarm_o,
    .console_baud_o);

// ===== ptsu_peer.sv
/* Far-side model: free-running 10 MHz reference and two pps sources.
   Assumes a 100 MHz core clock; outputs change just after an edge. */
module ptsu_peer #(
    parameter int unsigned PERIOD = 2000
) (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic en_zero_i,
    input  wire logic en_one_i,
    output logic      ref_tick_o,
    output logic      pps_zero_o,
    output logic      pps_one_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned div;
    int unsigned sec;
    // Divide for the reference tick and the one-second pulse
    always_ff @(posedge core_clk_i) begin
        div <= (!rst_n_i || div == 9) ? 0 : div + 1;
        sec <= (!rst_n_i || sec == PERIOD - 1) ? 0 : sec + 1;
    end
    // Pulses last 50 cycles, a source that is off stays low
    assign ref_tick_o = (div == 9);
    assign pps_zero_o = en_zero_i && (sec < 50);
    assign pps_one_o  = en_one_i && (sec < 50);
endmodule

// ===== ptsu_top_tb.sv
/* Self-checking bench for ptsu_top with shortened second and timeout.
   Assumes ptsu_peer drives the reference and the pps inputs. */
module ptsu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SEC = 2000;
    logic clk = 0, rst_n = 0, locked = 0, en0 = 0, en1 = 0;
    logic psel = 0, pen = 0, pwr = 0, slv, tick, p0, p1;
    logic ready, err, refo, ppso, lockn, alm, irq;
    logic [7:0] pa = 8'h00, cause = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic [1:0] baud;
    int err_total = 0, comparisons = 0, cyc = 0;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ptsu_peer #(.PERIOD(SEC)) peer_u (.core_clk_i(clk), .rst_n_i(rst_n),
        .en_zero_i(en0), .en_one_i(en1), .ref_tick_o(tick),
        .pps_zero_o(p0), .pps_one_o(p1));
    ptsu_top #(.SECOND_CYC(SEC), .TIMEOUT_CYC(3000)) dut_u (
        .core_clk_i(clk), .rst_n_i(rst_n), .ref_tick_i(tick),
        .pps_input_zero_i(p0), .pps_input_one_i(p1), .osc_locked_i(locked),
        .alarm_cause_i(cause), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(ready), .pslverr_o(err), .ref_out_o(refo),
        .pps_output_o(ppso), .lock_indicator_n_o(lockn), .alarm_o(alm),
        .irq_o(irq), .console_baud_o(baud));
    // -----------------------------------------------------------------
    // Tasks and expectations
    // -----------------------------------------------------------------
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; the extra edge keeps back-to-back calls clean
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ready === 1'b1) break;
        end
        if (i == 20) begin err_total++; give_verdict(); end
        q = prd; slv = err; psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, q, e);
    endtask
    // Returns 1 ns after the edge that first shows the pulse high
    task wait_rise(output int t);
        int i;
        logic p;
        p = 1'b1;
        for (i = 0; i < 3 * SEC; i++) begin
            @(posedge clk); #1;
            if (ppso === 1'b1 && p === 1'b0) break;
            p = ppso;
        end
        if (i == 3 * SEC) begin err_total++; give_verdict(); end
        t = cyc;
    endtask
    function automatic logic [31:0] cons(input logic [1:0] r);
        return {24'h0, ptsu_pkg::STOP_BITS, ptsu_pkg::DATA_BITS, r};
    endfunction
    function automatic int phase(input int t, input int o);
        return (t + 4 * SEC - o) % SEC;
    endfunction
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        int t, t0, base, w, o0, k, n;
        logic [7:0] c;
        void'($urandom(7353));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk("width", ptsu_pkg::OFS_WIDTH, 32'd2000);
        rd_chk("ctrl", ptsu_pkg::OFS_CTRL, 32'h0);
        rd_chk("console", ptsu_pkg::OFS_CONSOLE, cons(2'h0));
        rd_chk("unmapped", 8'h28, ptsu_pkg::ERR_DATA);
        chk("slverr", {31'h0, slv}, 32'h1);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, ptsu_pkg::OFS_CONSOLE, k);
            rd_chk("rate", ptsu_pkg::OFS_CONSOLE, cons(k == 3 ? 2 : k));
            chk("baud", baud, k == 3 ? 2 : k);
        end
        w = $urandom_range(20, 400);
        apb(1'b1, ptsu_pkg::OFS_WIDTH, w);
        wait_rise(t);
        wait_rise(t);
        n = 1;
        for (k = 0; k < SEC; k++) begin
            @(posedge clk); #1;
            if (ppso !== 1'b1) break;
            n++;
        end
        chk("pulse", n, w);
        wait_rise(t0);
        chk("period", t0 - t, SEC);
        base = phase(t0, 0);
        for (k = 0; k < 6; k++) begin
            o0 = (k == 1) ? SEC - 1 : $urandom_range(0, SEC - 1);
            @(posedge clk);
            apb(1'b1, (k < 4) ? ptsu_pkg::OFS_OFFSET0
                              : ptsu_pkg::OFS_OFFSET1, o0);
            if (k == 5) apb(1'b1, ptsu_pkg::OFS_CTRL, 32'h1);
            wait_rise(t);
            wait_rise(t);
            if (k < 4) t0 = o0;
            chk("phase", phase(t, k == 5 ? o0 : t0), base);
        end
        @(posedge clk);
        rd_chk("status", ptsu_pkg::OFS_STATUS, 32'h0);
        en1 <= 1'b1;
        repeat (2 * SEC) @(posedge clk);
        rd_chk("seen", ptsu_pkg::OFS_STATUS, 32'h1);
        en1 <= 1'b0;
        en0 <= 1'b1;
        repeat (2 * SEC) @(posedge clk);
        rd_chk("unselected", ptsu_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, ptsu_pkg::OFS_CTRL, 32'h0);
        repeat (2 * SEC) @(posedge clk);
        locked <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lock pin", lockn, 1'b0);
        rd_chk("locked", ptsu_pkg::OFS_STATUS, 32'h3);
        n = 0;
        for (k = 0; k < 200; k++) begin
            c[0] = refo;
            @(posedge clk);
            if (refo !== c[0]) n++;
        end
        chk("ref toggles", n, 20);
        locked <= 1'b0;
        repeat (3) @(posedge clk);
        chk("unlock pin", lockn, 1'b1);
        apb(1'b1, ptsu_pkg::OFS_IRQ_EN, 32'h8);
        c = $urandom_range(1, 255);
        cause <= c;
        @(posedge clk);
        cause <= 8'h00;
        repeat (3) @(posedge clk);
        chk("irq on", irq, 1'b1);
        rd_chk("alarm bits", ptsu_pkg::OFS_ALARM, c);
        rd_chk("alarm stat", ptsu_pkg::OFS_STATUS, 32'h5);
        apb(1'b1, ptsu_pkg::OFS_IRQ_EN, 32'h0);
        apb(1'b0, ptsu_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq masked", {irq, q[3]}, 2'b01);
        apb(1'b1, ptsu_pkg::OFS_IRQ_CLR, 32'h8);
        apb(1'b0, ptsu_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq cleared", {alm, q[3]}, 2'b10);
        apb(1'b1, ptsu_pkg::OFS_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        chk("alarm off", alm, 1'b0);
        rd_chk("alarm gone", ptsu_pkg::OFS_ALARM, 32'h0);
        give_verdict();
    end
endmodule
